// *** verilog/ihp_pkg.sv ***
// Purpose: Shared types and constants for the IP header octet packer
// Assumes: Header fields arrive in parallel from same-clock logic
// Notes: Field table drives the packer's walk, so widths live only here
package ihp_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Header layout, first field first
    localparam int unsigned NUM_FIELDS = 12;
    localparam int unsigned HDR_BITS = 160;
    localparam int unsigned NUM_OCTETS = 20;
    localparam int unsigned OCTET_BITS = 8;
    localparam int unsigned FLD_W [NUM_FIELDS] = '{4, 4, 8, 16, 16, 3, 13, 8, 8, 16, 32, 32};

    // Reset, start and end values of the walk, and the FIFO depth
    localparam logic [2:0] OBIT_FIRST = 3'h7;
    localparam logic [4:0] OIDX_FIRST = 5'h00;
    localparam logic [4:0] OIDX_LAST = 5'h13;
    localparam logic [3:0] FLD_FIRST = 4'h0;
    localparam logic [4:0] FBIT_FIRST = 5'h00;
    localparam int unsigned FIFO_DEPTH = 4;

    // Header field values, declared in header order so that packing
    // the struct gives the same bit stream the walk produces
    typedef struct packed {
        logic [3:0] version;
        logic [3:0] hdr_len;
        logic [7:0] tos;
        logic [15:0] total_len;
        logic [15:0] ident;
        logic [2:0] flags;
        logic [12:0] frag_off;
        logic [7:0] ttl;
        logic [7:0] protocol;
        logic [15:0] checksum;
        logic [31:0] src_addr;
        logic [31:0] dst_addr;
    } ihp_hdr_s;

    // One finished octet on its way to the link layer
    typedef struct packed {
        logic [7:0] data;
        logic [4:0] index;
        logic last;
    } ihp_octet_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_PACK = 2'h1,
        ST_PUSH = 2'h3
    } ihp_state_e;

    // Header bit number of the first bit of a field
    function automatic logic [7:0] field_start(input logic [3:0] idx);
        int unsigned acc;
        acc = 0;
        for (int unsigned i = 0; i < NUM_FIELDS; i++) begin
            if (i < idx) begin
                acc = acc + FLD_W[i];
            end
        end
        return acc[7:0];
    endfunction

endpackage

// *** verilog/ihp_packer.sv ***
// Purpose: Walk IP header fields bit by bit into octets, buffer, emit
// Assumes: One clock, synchronous active-high reset, same-clock source
// Notes: One bit placed per clock; about 180 cycles per header
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
// Small FIFO between the packer and the output stage
module ihp_fifo #(
    parameter int unsigned WIDTH = 14,
    parameter int unsigned DEPTH = 4
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wr;
        logic [AW:0] rd;
    } ihp_fifo_s;

    ihp_fifo_s s_q;
    ihp_fifo_s s_d;
    logic full;
    logic empty;

    // Extra pointer bit tells full from empty
    assign full = (s_q.wr[AW] != s_q.rd[AW]) && (s_q.wr[AW-1:0] == s_q.rd[AW-1:0]);
    assign empty = (s_q.wr == s_q.rd);
    assign in_ready_out = !full;
    assign out_valid_out = !empty;
    assign out_data_out = s_q.mem[s_q.rd[AW-1:0]];

    // Pointer and storage update
    always_comb begin
        s_d = s_q;
        if (in_valid_in && !full) begin
            s_d.mem[s_q.wr[AW-1:0]] = in_data_in;
            s_d.wr = s_q.wr + 1'b1;
        end
        if (out_ready_in && !empty) begin
            s_d.rd = s_q.rd + 1'b1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////
module ihp_packer #(
    parameter int unsigned FIFO_DEPTH = ihp_pkg::FIFO_DEPTH
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic hdr_valid_in,
    input wire ihp_pkg::ihp_hdr_s hdr_in,
    output logic hdr_ready_out,
    output logic oct_valid_out,
    output logic [7:0] oct_data_out,
    output logic [4:0] oct_index_out,
    output logic oct_last_out,
    input wire logic oct_ready_in
);
    typedef struct packed {
        ihp_pkg::ihp_state_e st;
        logic rdy;
        logic [ihp_pkg::HDR_BITS-1:0] hdr;
        logic [3:0] fld;
        logic [4:0] fbit;
        logic [2:0] obit;
        logic [7:0] acc;
        logic [4:0] oidx;
        logic ov;
        ihp_pkg::ihp_octet_s od;
    } ihp_packer_s;

    ihp_packer_s s_q;
    ihp_packer_s s_d;
    ihp_pkg::ihp_octet_s push_oct;
    ihp_pkg::ihp_octet_s fifo_oct;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic push;
    logic cur_bit;
    logic fld_done;
    logic [7:0] hdr_pos;

    ////////////////////////////////////////////////////////////////////////
    // Bit selection for the field and position being walked
    // layout from field table
    assign hdr_pos = 8'(ihp_pkg::HDR_BITS - 1) - (ihp_pkg::field_start(s_q.fld) + {3'h0, s_q.fbit});
    assign cur_bit = s_q.hdr[hdr_pos];
    assign fld_done = ({27'h0, s_q.fbit} == ihp_pkg::FLD_W[s_q.fld] - 1);
    assign push = (s_q.st == ihp_pkg::ST_PUSH);
    assign push_oct = '{data: s_q.acc, index: s_q.oidx, last: (s_q.oidx == ihp_pkg::OIDX_LAST)};
    // Output stage refills whenever it is empty or being drained
    assign fifo_out_ready = !s_q.ov || oct_ready_in;

    ihp_fifo #(
        .WIDTH($bits(ihp_pkg::ihp_octet_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .in_valid_in(push),
        .in_ready_out(fifo_in_ready),
        .in_data_in(push_oct),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(fifo_out_ready),
        .out_data_out(fifo_oct)
    );

    ////////////////////////////////////////////////////////////////////////
    // Walk and output stage next state
    always_comb begin
        s_d = s_q;
        unique case (s_q.st)
            ihp_pkg::ST_IDLE: begin
                if (hdr_valid_in && s_q.rdy) begin
                    s_d.hdr = hdr_in;
                    s_d.rdy = 1'b0;
                    s_d.st = ihp_pkg::ST_PACK;
                    s_d.fld = ihp_pkg::FLD_FIRST;
                    s_d.fbit = ihp_pkg::FBIT_FIRST;
                    s_d.oidx = ihp_pkg::OIDX_FIRST;
                    s_d.obit = ihp_pkg::OBIT_FIRST;
                    s_d.acc = 8'h00;
                end
            end
            ihp_pkg::ST_PACK: begin
                s_d.acc[s_q.obit] = cur_bit;
                if (fld_done) begin
                    s_d.fld = s_q.fld + 4'h1;
                    s_d.fbit = ihp_pkg::FBIT_FIRST;
                end else begin
                    s_d.fbit = s_q.fbit + 5'h01;
                end
                if (s_q.obit == 3'h0) begin
                    s_d.st = ihp_pkg::ST_PUSH;
                end else begin
                    s_d.obit = s_q.obit - 3'h1;
                end
            end
            ihp_pkg::ST_PUSH: begin
                // Stalls here while the FIFO is full
                if (fifo_in_ready) begin
                    s_d.oidx = s_q.oidx + 5'h01;
                    s_d.obit = ihp_pkg::OBIT_FIRST;
                    s_d.acc = 8'h00;
                    if (push_oct.last) begin
                        s_d.st = ihp_pkg::ST_IDLE;
                        s_d.rdy = 1'b1;
                    end else begin
                        s_d.st = ihp_pkg::ST_PACK;
                    end
                end
            end
            default: begin
                s_d.st = ihp_pkg::ST_IDLE;
                s_d.rdy = 1'b1;
            end
        endcase
        if (fifo_out_ready) begin
            s_d.ov = fifo_out_valid;
            if (fifo_out_valid) begin
                s_d.od = fifo_oct;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            s_q <= '0;
            s_q.rdy <= 1'b1;
            s_q.obit <= ihp_pkg::OBIT_FIRST;
        end else begin
            s_q <= s_d;
        end
    end

    assign hdr_ready_out = s_q.rdy;
    assign oct_valid_out = s_q.ov;
    assign oct_data_out = s_q.od.data;
    assign oct_index_out = s_q.od.index;
    assign oct_last_out = s_q.od.last;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic [4:0] last_idx_q;
    logic seen_q;
    logic walk_bit;

    // Header bit that belongs at this octet and weight, found from the octet
    // position alone so that a wrong field table cannot hide behind itself
    assign walk_bit = s_q.hdr[8'(ihp_pkg::HDR_BITS - 8) - {s_q.oidx, 3'h0} + {5'h00, s_q.obit}];

    // Remembers the index of the last accepted octet
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            last_idx_q <= 5'h00;
            seen_q <= 1'b0;
        end else if (oct_valid_out && oct_ready_in) begin
            last_idx_q <= oct_index_out;
            seen_q <= !oct_last_out;
        end
    end

    sequence start_seq;
        s_q.st == ihp_pkg::ST_IDLE && hdr_valid_in && hdr_ready_out;
    endsequence

    sequence push_done_seq;
        push && fifo_in_ready;
    endsequence

    octet_value_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        push |-> s_q.acc == s_q.hdr[8'(ihp_pkg::HDR_BITS - 1) - {s_q.oidx, 3'h0} -: 8])
        else $error("Octet does not match header bits");

    field_carry_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        (s_q.st == ihp_pkg::ST_PACK && s_q.obit == 3'h0 && !fld_done)
        |=> push && s_q.fbit == $past(s_q.fbit) + 5'h01 ##1 s_q.fld == $past(s_q.fld, 2))
        else $error("Field split across octets lost its place");

    field_order_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        (s_q.st == ihp_pkg::ST_PACK && fld_done) |=> s_q.fld == $past(s_q.fld) + 4'h1)
        else $error("Field order broken");

    index_start_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        start_seq |=> s_q.oidx == ihp_pkg::OIDX_FIRST ##8 push && s_q.oidx == ihp_pkg::OIDX_FIRST)
        else $error("First octet not at index zero");

    bit_weight_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        s_q.st == ihp_pkg::ST_PACK |=> s_q.acc[$past(s_q.obit)] == $past(walk_bit))
        else $error("Bit placed at wrong weight");

    header_end_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        (push_done_seq ##0 push_oct.last) |=> s_q.fld == 4'(ihp_pkg::NUM_FIELDS) && hdr_ready_out)
        else $error("Header ended off the field table");

    out_hold_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        (oct_valid_out && !oct_ready_in) |=> oct_valid_out && $stable(oct_data_out) && $stable(oct_index_out))
        else $error("Octet dropped before acceptance");

    out_order_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        (oct_valid_out && seen_q) |-> oct_index_out == last_idx_q + 5'h01)
        else $error("Octets out of order");
endmodule

// *** verif/ihp_link_model.sv ***
// Purpose: Link layer sink that takes octets from the packer
// Assumes: Same clock as the packer, ready driven at the falling edge
// Notes: Stall count sets how long ready stays low before each take
`timescale 1ns/100ps

module ihp_link_model (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic oct_valid_in,
    input wire logic [7:0] oct_data_in,
    input wire logic [4:0] oct_index_in,
    input wire logic oct_last_in,
    input wire logic [7:0] stall_in,
    output logic oct_ready_out
);
    logic [7:0] data_q [$];
    logic [4:0] index_q [$];
    logic last_q [$];
    logic ready_q = 1'b0;
    int take_cnt = 0;
    int seen_cnt = 0;
    int wait_cnt = 0;

    // Each variable has one writing process; takes are counted, not flagged
    assign oct_ready_out = ready_q;

    ////////////////////////////////////////////////////////////////////////
    // one octet per transfer
    always @(posedge core_clk_in) begin
        if (!sys_rst_in && oct_valid_in === 1'b1 && ready_q) begin
            data_q.push_back(oct_data_in);
            index_q.push_back(oct_index_in);
            last_q.push_back(oct_last_in);
            take_cnt = take_cnt + 1;
        end
    end

    // Ready drops after each take while stall_in is nonzero so that slow links really stall the FIFO
    always @(negedge core_clk_in) begin
        if (sys_rst_in || (take_cnt != seen_cnt && stall_in != 8'h00)) begin
            ready_q = 1'b0;
            wait_cnt = 0;
        end else if (wait_cnt >= stall_in) begin
            ready_q = 1'b1;
        end else begin
            wait_cnt = wait_cnt + 1;
        end
        seen_cnt = take_cnt;
    end
endmodule

// *** verif/ihp_packer_tb_top.sv ***
// Purpose: Self-checking bench for the IP header octet packer
// Assumes: Inputs change at the falling edge; the sink takes outputs at the rising edge, checks read them at either edge
// Notes: Expected octets come from the header struct in field order
`timescale 1ns/100ps

module ihp_packer_tb_top;
    logic core_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic hdr_valid_in = 1'b0;
    ihp_pkg::ihp_hdr_s hdr_in = '0;
    logic hdr_ready_out, oct_valid_out, oct_last_out, oct_ready_in;
    logic [7:0] oct_data_out;
    logic [4:0] oct_index_out;
    logic [7:0] stall = 8'h00;
    int failures = 0;
    int checked = 0;
    int base = 0;

    always #12.5 core_clk_in = ~core_clk_in;

    ihp_packer ihp_packer_inst (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
        .hdr_valid_in(hdr_valid_in), .hdr_in(hdr_in), .hdr_ready_out(hdr_ready_out),
        .oct_valid_out(oct_valid_out), .oct_data_out(oct_data_out), .oct_index_out(oct_index_out),
        .oct_last_out(oct_last_out), .oct_ready_in(oct_ready_in));
    ihp_link_model ihp_link_model_inst (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
        .oct_valid_in(oct_valid_out), .oct_data_in(oct_data_out), .oct_index_in(oct_index_out),
        .oct_last_in(oct_last_out), .stall_in(stall), .oct_ready_out(oct_ready_in));

    ////////////////////////////////////////////////////////////////////////
    // Shared comparison and closing
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wrap_up();
        if (failures == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Offer one header and hold it until the edge that takes it
    task automatic send_hdr(input ihp_pkg::ihp_hdr_s h);
        int i;
        @(negedge core_clk_in);
        hdr_valid_in = 1'b1;
        hdr_in = h;
        for (i = 0; i < 400; i++) begin
            @(posedge core_clk_in);
            if (hdr_ready_out === 1'b1) break;
        end
        if (i == 400) failures++;
        @(negedge core_clk_in);
        hdr_valid_in = 1'b0;
        hdr_in = ~h;
        check("hdr_ready_busy", hdr_ready_out, 1'b0);
    endtask

    // Wait for the sink to hold 20 more octets, then compare them
    task automatic expect_hdr(input ihp_pkg::ihp_hdr_s h);
        int i;
        for (i = 0; i < 4000 && ihp_link_model_inst.data_q.size() < base + 20; i++) begin
            @(posedge core_clk_in);
        end
        if (i == 4000) failures++;
        for (int k = 0; k < 20; k++) begin
            check("oct_data", ihp_link_model_inst.data_q[base + k], h[159 - 8 * k -: 8]);
            check("oct_index", ihp_link_model_inst.index_q[base + k], k);
            check("oct_last", ihp_link_model_inst.last_q[base + k], k == 19);
        end
        base += 20;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Example header against its known octets, prompt sink
    task automatic test_example();
        ihp_pkg::ihp_hdr_s h;
        logic [7:0] ex [20] = '{8'h45, 8'h00, 8'h00, 8'h34, 8'h00, 8'h01, 8'h00, 8'h00, 8'h32, 8'h11,
            8'h0F, 8'hFB, 8'hC0, 8'h1F, 8'h7C, 8'h41, 8'hC0, 8'h1F, 8'h7C, 8'h3D};
        h = '{4'h4, 4'h5, 8'h00, 16'h0034, 16'h0001, 3'h0, 13'h0000, 8'h32, 8'h11, 16'h0FFB,
            32'hC01F7C41, 32'hC01F7C3D};
        stall = 8'h00;
        send_hdr(h);
        expect_hdr(h);
        for (int k = 0; k < 20; k++) begin
            check("example_octet", ihp_link_model_inst.data_q[k], ex[k]);
        end
    endtask

    // Fields straddling octets, slow sink so the FIFO fills and the packer stalls
    task automatic test_straddle_stall();
        ihp_pkg::ihp_hdr_s h;
        h = '{4'hF, 4'h0, 8'hA5, 16'h8001, 16'h7FFE, 3'h5, 13'h1ABC, 8'h01, 8'h80, 16'hC33C,
            32'h80000001, 32'h0F0FF0F0};
        stall = 8'h0C;
        send_hdr(h);
        expect_hdr(h);
        repeat (4) @(negedge core_clk_in);
        check("oct_valid_idle", oct_valid_out, 1'b0);
        check("hdr_ready_idle", hdr_ready_out, 1'b1);
    endtask

    // Second header offered while the first is packing; index restarts at zero
    task automatic test_back_to_back();
        ihp_pkg::ihp_hdr_s a, b;
        a = '{4'h6, 4'h9, 8'h3C, 16'hFFFF, 16'h1234, 3'h7, 13'h0001, 8'hFE, 8'h06, 16'h5AA5,
            32'hDEADBEEF, 32'h00000000};
        b = ~a;
        stall = 8'h00;
        send_hdr(a);
        send_hdr(b);
        expect_hdr(a);
        expect_hdr(b);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial begin
        repeat (2) @(negedge core_clk_in);
        check("rst_hdr_ready", hdr_ready_out, 1'b1);
        check("rst_oct_valid", oct_valid_out, 1'b0);
        check("rst_oct_index", oct_index_out, 5'h00);
        sys_rst_in = 1'b0;
        test_example();
        test_straddle_stall();
        test_back_to_back();
        wrap_up();
    end

    initial begin
        #500000;
        failures++;
        wrap_up();
    end
endmodule
